// file: rtl/cra_cursor_access.sv
// Cursor pattern RAM host access, control registers and retrace detection
`timescale 1ns/1ps
module cra_cursor_access (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [3:0] RS,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [7:0] D_IN,
  output logic [7:0] D_OUT,
  output logic D_OE,
  input wire logic BLANK,
  input wire cra_pkg::cra_coord_t DISP_POS,
  output logic [1:0] CURSOR_PIX,
  output logic [1:0] CURSOR_MODE,
  output logic CURSOR_ON,
  output logic INTERLACE_EN,
  output logic ODD_EVEN_INVERT,
  output logic VRETRACE
);

  function automatic logic [cra_pkg::ADDR_W-1:0] next_addr_of(
    input logic [cra_pkg::ADDR_W-1:0] a
  );
    next_addr_of = a + 10'h001;
  endfunction

  function automatic logic pick_bit(
    input logic [7:0] b,
    input logic [2:0] col
  );
    // D7 is the leftmost pixel of the eight
    pick_bit = b[3'h7 - col];
  endfunction

  logic wr_n_q;
  logic rd_n_q;
  logic wr_start;
  logic rd_end;

  cra_pkg::cra_ctrl_t ctrl;
  logic [7:0] write_ptr;
  logic [7:0] read_ptr;
  logic [cra_pkg::ADDR_W-1:0] addr_cnt;
  logic [cra_pkg::ADDR_W-1:0] next_addr;
  logic step_addr;

  cra_pkg::cra_host_port_t host;
  logic [7:0] ram_rdata;
  logic [7:0] next_dout;

  logic [cra_pkg::PLANE_W-1:0] disp_addr;
  logic [7:0] plane0_byte;
  logic [7:0] plane1_byte;
  logic [2:0] col_q;

  logic blank_q;
  logic blank_rise;
  logic armed;
  logic [cra_pkg::RETRACE_CNT_W-1:0] gap_cnt;
  logic [cra_pkg::RETRACE_CNT_W-1:0] gap_limit;

  // Strobes are synchronous levels; act once per low pulse
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= WR_N;
      rd_n_q <= RD_N;
    end
  end

  assign wr_start = wr_n_q & ~WR_N;
  assign rd_end = ~rd_n_q & RD_N;

  assign next_addr = next_addr_of(addr_cnt);

  // Data reads advance only when the read completes, at strobe release
  always_comb begin
    step_addr = 1'b0;
    if (wr_start && RS == cra_pkg::REG_PATTERN_DATA) begin
      step_addr = 1'b1;
    end
    if (rd_end && RS == cra_pkg::REG_PATTERN_DATA) begin
      step_addr = 1'b1;
    end
  end

  // Low address pointers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      write_ptr <= cra_pkg::PTR_RESET;
      read_ptr <= cra_pkg::PTR_RESET;
    end else if (wr_start) begin
      if (RS == cra_pkg::REG_WRITE_PTR) begin
        write_ptr <= D_IN;
      end
      if (RS == cra_pkg::REG_READ_PTR) begin
        read_ptr <= D_IN;
      end
    end
  end

  // Full 10-bit counter; upper bits only taken on a low address write
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      addr_cnt <= '0;
    end else if (wr_start && (RS == cra_pkg::REG_WRITE_PTR ||
                              RS == cra_pkg::REG_READ_PTR)) begin
      addr_cnt <= {ctrl.ram_addr_bit9, ctrl.ram_addr_bit8, D_IN};
    end else if (step_addr) begin
      addr_cnt <= next_addr;
    end
  end

  // Control register: indirect at its index, mode also reachable directly
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl <= cra_pkg::CTRL_RESET;
    end else if (wr_start && RS == cra_pkg::REG_INDEX_DATA &&
                 write_ptr == cra_pkg::IDX_POINTER_CTRL) begin
      ctrl <= D_IN;
    end else if (wr_start && RS == cra_pkg::REG_DIRECT_CTRL) begin
      ctrl.cursor_mode_hi <= D_IN[cra_pkg::BIT_MODE_HI];
      ctrl.cursor_mode_lo <= D_IN[cra_pkg::BIT_MODE_LO];
    end else if (step_addr && addr_cnt[7:0] == 8'hff) begin
      // Roll-over carries into the visible upper address bits
      ctrl.ram_addr_bit9 <= next_addr[9];
      ctrl.ram_addr_bit8 <= next_addr[8];
    end
  end

  // Host port of the RAM always addresses the counter
  always_comb begin
    host.we = wr_start && RS == cra_pkg::REG_PATTERN_DATA;
    host.addr = addr_cnt;
    host.wdata = D_IN;
  end

  // Display fetch: eight bytes per row, rows top to bottom
  assign disp_addr = {DISP_POS.y, DISP_POS.x[5:3]};

  cra_pattern_ram u_ram (
    .clk(CLOCK),
    .host(host),
    .host_rdata(ram_rdata),
    .disp_addr(disp_addr),
    .disp_plane0(plane0_byte),
    .disp_plane1(plane1_byte)
  );

  // Read mux
  always_comb begin
    next_dout = 8'h00;
    unique case (RS)
      cra_pkg::REG_WRITE_PTR: next_dout = write_ptr;
      cra_pkg::REG_READ_PTR: next_dout = read_ptr;
      cra_pkg::REG_PATTERN_DATA: next_dout = ram_rdata;
      cra_pkg::REG_DIRECT_CTRL: begin
        next_dout[cra_pkg::BIT_MODE_HI] = ctrl.cursor_mode_hi;
        next_dout[cra_pkg::BIT_MODE_LO] = ctrl.cursor_mode_lo;
      end
      cra_pkg::REG_INDEX_DATA: begin
        if (write_ptr == cra_pkg::IDX_POINTER_CTRL) begin
          next_dout = ctrl;
        end
      end
      default: next_dout = 8'h00;
    endcase
  end

  // Registered read data; the bus pin is driven only during a read
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      D_OUT <= 8'h00;
    end else begin
      D_OUT <= next_dout;
    end
  end

  assign D_OE = ~RD_N;

  // Pixel column kept alongside the RAM read so bit select lines up
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      col_q <= 3'h0;
    end else begin
      col_q <= DISP_POS.x[2:0];
    end
  end

  // Two-bit pixel code: plane 1 high, plane 0 low
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CURSOR_PIX <= 2'h0;
    end else begin
      CURSOR_PIX <= {pick_bit(plane1_byte, col_q), pick_bit(plane0_byte, col_q)};
    end
  end

  // Mode outputs straight from the control register flops
  assign CURSOR_MODE = {ctrl.cursor_mode_hi, ctrl.cursor_mode_lo};
  assign CURSOR_ON = CURSOR_MODE != cra_pkg::MODE_OFF;
  assign INTERLACE_EN = ctrl.interlace_en;
  assign ODD_EVEN_INVERT = ctrl.odd_even_invert;

  // Retrace detection on the blanking signal
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      blank_q <= 1'b0;
    end else begin
      blank_q <= BLANK;
    end
  end

  assign blank_rise = BLANK & ~blank_q;

  assign gap_limit = ctrl.retrace_window_select ?
                     cra_pkg::RETRACE_CNT_W'(cra_pkg::RETRACE_LONG) :
                     cra_pkg::RETRACE_CNT_W'(cra_pkg::RETRACE_SHORT);

  // Saturating count; a horizontal gap never reaches the limit
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      gap_cnt <= '0;
    end else if (blank_rise) begin
      gap_cnt <= cra_pkg::RETRACE_CNT_W'(1);
    end else if (gap_cnt != cra_pkg::RETRACE_CNT_W'(cra_pkg::RETRACE_LONG)) begin
      gap_cnt <= gap_cnt + cra_pkg::RETRACE_CNT_W'(1);
    end
  end

  // First rise after reset has no earlier rise to measure from, so it never pulses
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      armed <= 1'b0;
    end else if (blank_rise) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      VRETRACE <= 1'b0;
    end else begin
      VRETRACE <= blank_rise && armed && gap_cnt >= gap_limit;
    end
  end

endmodule

// file: rtl/cra_pattern_ram.sv
// Pattern storage: one host read/write port and one display read port for both planes
`timescale 1ns/1ps
module cra_pattern_ram (
  input wire logic clk,
  input wire cra_pkg::cra_host_port_t host,
  output logic [7:0] host_rdata,
  input wire logic [cra_pkg::PLANE_W-1:0] disp_addr,
  output logic [7:0] disp_plane0,
  output logic [7:0] disp_plane1
);

  // No reset on the array: contents are undefined until written
  logic [7:0] mem [0:cra_pkg::RAM_DEPTH-1];

  always_ff @(posedge clk) begin
    if (host.we) begin
      mem[host.addr] <= host.wdata;
    end
    host_rdata <= mem[host.addr];
  end

  // Separate read port, so display fetches never block the host
  always_ff @(posedge clk) begin
    disp_plane0 <= mem[{1'b0, disp_addr}];
    disp_plane1 <= mem[{1'b1, disp_addr}];
  end

endmodule

// file: rtl/cra_pkg.sv
// Package: register map, field layout and timing constants for the cursor pattern access block
package cra_pkg;

  localparam int ADDR_W = 10;
  localparam int PLANE_W = 9;
  localparam int RAM_DEPTH = 1024;

  localparam logic [3:0] REG_WRITE_PTR = 4'h0;
  localparam logic [3:0] REG_READ_PTR = 4'h3;
  localparam logic [3:0] REG_DIRECT_CTRL = 4'h9;
  localparam logic [3:0] REG_INDEX_DATA = 4'ha;
  localparam logic [3:0] REG_PATTERN_DATA = 4'hb;

  localparam logic [7:0] IDX_POINTER_CTRL = 8'h06;

  localparam int BIT_MODE_LO = 0;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_ADDR8 = 2;
  localparam int BIT_ADDR9 = 3;
  localparam int BIT_RETRACE_SEL = 4;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_THREE_COLOUR = 2'h1;
  localparam logic [1:0] MODE_STANDARD = 2'h2;
  localparam logic [1:0] MODE_WINDOWING = 2'h3;

  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam logic [7:0] PTR_RESET = 8'h00;

  localparam int RETRACE_SHORT = 2048;
  localparam int RETRACE_LONG = 4096;
  localparam int RETRACE_CNT_W = 13;

  typedef struct packed {
    logic odd_even_invert;
    logic interlace_en;
    logic spare;
    logic retrace_window_select;
    logic ram_addr_bit9;
    logic ram_addr_bit8;
    logic cursor_mode_hi;
    logic cursor_mode_lo;
  } cra_ctrl_t;

  typedef struct packed {
    logic [5:0] y;
    logic [5:0] x;
  } cra_coord_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } cra_host_port_t;

endpackage

// file: sim/cra_access_props.sv
// Checker for the cursor access block ports
`timescale 1ns/1ps
module cra_access_props (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic BLANK,
  input wire logic D_OE,
  input wire logic [1:0] CURSOR_MODE,
  input wire logic CURSOR_ON,
  input wire logic VRETRACE
);
  logic [12:0] gap;
  logic seen;
  logic blank_q;
  logic rise;
  assign rise = BLANK && !blank_q;
  // Gap saturates well above both thresholds so it never wraps
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      gap <= 13'h0;
      seen <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      blank_q <= BLANK;
      if (rise) begin
        gap <= 13'h1;
        seen <= 1'b1;
      end else if (gap != 13'h1fff) begin
        gap <= gap + 13'h1;
      end
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  chk_mode_on: assert property (CURSOR_ON == (CURSOR_MODE != 2'h0))
    else $error("cursor on flag disagrees with mode");
  chk_reset_mode: assert property ($rose(RST_N) |-> CURSOR_MODE == 2'h2)
    else $error("mode after reset not standard");
  chk_mode_cause: assert property ($changed(CURSOR_MODE) |-> !$past(WR_N) || !$past(WR_N, 2))
    else $error("mode changed without a write");
  chk_oe_read: assert property (D_OE == !RD_N)
    else $error("drive enable does not follow read strobe");
  chk_pulse_origin: assert property (VRETRACE |-> $past(BLANK) && !$past(BLANK, 2))
    else $error("retrace pulse without blank rise");
  chk_pulse_single: assert property (VRETRACE |=> !VRETRACE)
    else $error("retrace pulse too long");
  chk_short_gap: assert property (rise && gap < 13'h800 |=> !VRETRACE)
    else $error("retrace on short gap");
  chk_long_gap: assert property (rise && seen && gap >= 13'h1000 |=> VRETRACE)
    else $error("no retrace on long gap");
  cover property (VRETRACE);
  cover property (!WR_N);
  cover property ($changed(CURSOR_MODE));
endmodule

bind cra_cursor_access cra_access_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .WR_N(WR_N),
  .RD_N(RD_N), .BLANK(BLANK), .D_OE(D_OE), .CURSOR_MODE(CURSOR_MODE),
  .CURSOR_ON(CURSOR_ON), .VRETRACE(VRETRACE));

// file: sim/testbench.sv
// Testbench for the cursor pattern access block
`timescale 1ns/1ps
module testbench;
  logic CLOCK, RST_N, WR_N, RD_N, BLANK, D_OE, CURSOR_ON, VRETRACE;
  logic INTERLACE_EN, ODD_EVEN_INVERT;
  logic [3:0] RS;
  logic [7:0] D_IN, D_OUT;
  logic [1:0] CURSOR_PIX, CURSOR_MODE;
  cra_pkg::cra_coord_t DISP_POS;
  int bad_count = 0;
  int total_checks = 0;
  int pulses = 0;
  cra_cursor_access dut (.CLOCK(CLOCK), .RST_N(RST_N), .RS(RS), .WR_N(WR_N), .RD_N(RD_N),
    .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE), .BLANK(BLANK), .DISP_POS(DISP_POS),
    .CURSOR_PIX(CURSOR_PIX), .CURSOR_MODE(CURSOR_MODE), .CURSOR_ON(CURSOR_ON),
    .INTERLACE_EN(INTERLACE_EN), .ODD_EVEN_INVERT(ODD_EVEN_INVERT), .VRETRACE(VRETRACE));
  initial begin
    CLOCK = 0;
    forever #4 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) if (VRETRACE === 1'b1) pulses++;
  task print_verdict;
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    #1 RS = a;
    D_IN = d;
    WR_N = 0;
    @(posedge CLOCK);
    #1 WR_N = 1;
  endtask
  // Strobe held four cycles: pattern data needs two edges after the counter settles
  task rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    #1 RS = a;
    RD_N = 0;
    repeat (4) @(posedge CLOCK);
    #1 chk("D_OUT", e, D_OUT);
    chk("D_OE", 8'h01, {7'h0, D_OE});
    RD_N = 1;
  endtask
  // Rises n cycles apart; the count check sits inside so the gap stays exact
  task rise(input int n, input int e);
    repeat (n - 3) @(posedge CLOCK);
    #1 BLANK = 1;
    @(posedge CLOCK);
    #1 BLANK = 0;
    repeat (2) @(posedge CLOCK);
    #1 chk("VRETRACE count", 8'(e), 8'(pulses));
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    print_verdict;
  end
  initial begin
    RST_N = 0;
    WR_N = 1;
    RD_N = 1;
    BLANK = 0;
    RS = 4'h0;
    D_IN = 8'h00;
    DISP_POS = '0;
    repeat (5) @(posedge CLOCK);
    #1 RST_N = 1;
    chk("CURSOR_MODE", 8'h02, {6'h0, CURSOR_MODE});
    rc(4'h9, 8'h02);
    wr(4'h0, 8'h06);
    rc(4'ha, 8'h02);
    wr(4'h5, 8'hff);
    rc(4'h5, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(4'h9, 8'(m));
      repeat (2) @(posedge CLOCK);
      #1 chk("CURSOR_MODE", 8'(m), {6'h0, CURSOR_MODE});
      chk("CURSOR_ON", 8'(m != 0), {7'h0, CURSOR_ON});
      rc(4'ha, 8'(m));
    end
    wr(4'ha, 8'h02);
    wr(4'h0, 8'hfe);
    for (int i = 0; i < 3; i++) wr(4'hb, 8'(8'ha1 + 8'h11 * i));
    wr(4'h0, 8'h06);
    rc(4'ha, 8'h06);
    wr(4'ha, 8'h02);
    wr(4'h3, 8'hfe);
    for (int i = 0; i < 3; i++) rc(4'hb, 8'(8'ha1 + 8'h11 * i));
    wr(4'h0, 8'h06);
    rc(4'ha, 8'h06);
    wr(4'ha, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'hb, 8'h80);
    wr(4'h0, 8'h06);
    wr(4'ha, 8'h0a);
    wr(4'h0, 8'h00);
    wr(4'hb, 8'h40);
    wr(4'h0, 8'h06);
    wr(4'ha, 8'hc2);
    @(posedge CLOCK);
    #1 chk("INTERLACE_EN", 8'h01, {7'h0, INTERLACE_EN});
    chk("ODD_EVEN_INVERT", 8'h01, {7'h0, ODD_EVEN_INVERT});
    wr(4'ha, 8'h02);
    @(posedge CLOCK);
    #1 chk("INTERLACE_EN", 8'h00, {7'h0, INTERLACE_EN});
    chk("ODD_EVEN_INVERT", 8'h00, {7'h0, ODD_EVEN_INVERT});
    for (int x = 0; x < 2; x++) begin
      DISP_POS = {6'h0, 6'(x)};
      repeat (3) @(posedge CLOCK);
      #1 chk("CURSOR_PIX", (x == 1) ? 8'h02 : 8'h01, {6'h0, CURSOR_PIX});
    end
    rise(10, 0);
    rise(2047, 0);
    rise(2048, 1);
    wr(4'ha, 8'h12);
    rise(100, 1);
    rise(4095, 1);
    rise(4096, 2);
    print_verdict;
  end
endmodule
